// ---- src/idio_i2c_writer.v ----
// i2c master that writes one address byte and two data bytes
`timescale 1ns/1ps
`default_nettype none
`include "idio_map.vh"
module idio_i2c_writer #(
	parameter [15:0] QTR_CYC = `IDIO_I2C_QTR
) (
	input wire core_clk_in, // system clock
	input wire rst_n_in, // synchronised reset, active low
	input wire start_in, // one-cycle request to send a word
	input wire [15:0] word_in, // word to send, low byte first
	input wire sda_in, // synchronised bus data level
	output wire busy_out, // transfer in progress
	output reg nack_out, // last transfer saw a missing acknowledge
	output reg scl_oe_out, // high pulls clock low
	output reg sda_oe_out // high pulls data low
);
	localparam ST_IDLE = 4'h1;
	localparam ST_START = 4'h2;
	localparam ST_BITS = 4'h4;
	localparam ST_STOP = 4'h8;
	reg [3:0] state_r;
	reg [15:0] qtr_r;
	reg [1:0] phase_r;
	reg [26:0] shift_r;
	reg [4:0] bitn_r;
	reg tick;
	reg [1:0] stopn_r;
	assign busy_out = (state_r != ST_IDLE);
	always @* begin
		tick = (qtr_r == QTR_CYC - 16'h0001);
	end
	// frame: addr+w, ack, low byte, ack, high byte, ack (released bits = 1)
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			qtr_r <= 16'h0000;
			phase_r <= 2'h0;
			shift_r <= 27'h0000000;
			bitn_r <= 5'h00;
			stopn_r <= 2'h0;
			nack_out <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			qtr_r <= tick ? 16'h0000 : qtr_r + 16'h0001;
			case (state_r)
			ST_IDLE: begin
				scl_oe_out <= 1'b0;
				sda_oe_out <= 1'b0;
				if (start_in) begin
					shift_r <= {`IDIO_I2C_ADDR, 1'b0, 1'b1, word_in[7:0],
						1'b1, word_in[15:8], 1'b1};
					bitn_r <= 5'h00;
					phase_r <= 2'h0;
					nack_out <= 1'b0;
					state_r <= ST_START;
				end
			end
			ST_START: if (tick) begin
				phase_r <= phase_r + 2'h1;
				if (phase_r == 2'h0)
					sda_oe_out <= 1'b1;
				if (phase_r == 2'h1) begin
					scl_oe_out <= 1'b1;
					phase_r <= 2'h0;
					state_r <= ST_BITS;
				end
			end
			ST_BITS: if (tick) begin
				phase_r <= phase_r + 2'h1;
				case (phase_r)
				2'h0: sda_oe_out <= ~shift_r[26];
				2'h1: scl_oe_out <= 1'b0;
				2'h2: begin
					if ((bitn_r == 5'd8 || bitn_r == 5'd17 ||
						bitn_r == 5'd26) && sda_in)
						nack_out <= 1'b1;
				end
				default: begin
					scl_oe_out <= 1'b1;
					shift_r <= {shift_r[25:0], 1'b1};
					bitn_r <= bitn_r + 5'h01;
					if (bitn_r == 5'd26) begin
						stopn_r <= 2'h0;
						state_r <= ST_STOP;
					end
				end
				endcase
			end
			ST_STOP: if (tick) begin
				stopn_r <= stopn_r + 2'h1;
				case (stopn_r)
				2'h0: sda_oe_out <= 1'b1;
				2'h1: scl_oe_out <= 1'b0;
				default: begin
					sda_oe_out <= 1'b0;
					state_r <= ST_IDLE;
				end
				endcase
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- src/idio_map.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef IDIO_MAP_VH
`define IDIO_MAP_VH
`define IDIO_ADDR_CTL_LOW 10'h321
`define IDIO_ADDR_INTERNAL 10'h322
`define IDIO_ADDR_STATUS_A 10'h323
`define IDIO_ADDR_STATUS_B 10'h324
`define IDIO_ADDR_CTL_HIGH 10'h325
`define IDIO_CTL_IN_W 6
`define IDIO_CTL_HIGH_OUT_W 4
`define IDIO_SPARE_FILL 2'h3
`define IDIO_PORT_RESET 8'hff
`define IDIO_RELAY_RESET 16'hffff
`define IDIO_ST_HEALTHY 0
`define IDIO_ST_SPARE1 1
`define IDIO_ST_SEQUENCE 2
`define IDIO_ST_DIAG 3
`define IDIO_ST_THERMAL 4
`define IDIO_ST_PRESSURE 5
`define IDIO_ST_SPARE6 6
`define IDIO_ST_SPARE7 7
`define IDIO_RB_KEEPALIVE 0
`define IDIO_RB_VENT 1
`define IDIO_RB_TUBE_TWO_HEATER 2
`define IDIO_RB_BYPASS 5
`define IDIO_RB_PATH_SELECT 6
`define IDIO_RB_GENERATOR_VALVE 7
`define IDIO_RB_PUMP 8
`define IDIO_RB_DIVERT 9
`define IDIO_RB_SHUTOFF_B 10
`define IDIO_RB_PERM_VALVE_1 11
`define IDIO_RB_PERM_VALVE_2 12
`define IDIO_RB_TUBE_ONE_HEATER 13
`define IDIO_RB_LAMP_HEAT 14
`define IDIO_RB_GEN_LAMP_HEAT 15
`define IDIO_I2C_ADDR 7'h44
`define IDIO_CLK_HZ 25000000
`define IDIO_KEEPALIVE_MS 5000
`define IDIO_KEEPALIVE_CYC ((`IDIO_CLK_HZ / 1000) * `IDIO_KEEPALIVE_MS)
`define IDIO_REFRESH_MS 1000
`define IDIO_REFRESH_CYC ((`IDIO_CLK_HZ / 1000) * `IDIO_REFRESH_MS)
`define IDIO_I2C_KHZ 100
// quarter of a 100 khz bit at 25 mhz, sized to the 16-bit quarter counter
`define IDIO_I2C_QTR 16'd62
`endif

// ---- src/idio_ports.v ----
// digital i/o ports: control, spare and status ports plus relay expander
`timescale 1ns/1ps
`default_nettype none
`include "idio_map.vh"
// Behaviour
// - port 321 read gives inputs one to six active low on bits 0-5
// - port 325 read gives inputs seven to twelve on bits 0-5, 6-7 read 1
// - port 321 write drives control outputs one to eight, 0 asserts
// - port 325 write drives control outputs nine to twelve from bits 0-3
// - spare eight-bit internal input port reads at 322
// - spare eight-bit internal output port writes at 322
// - status port A written at 323 drives eight lines, bits 1,6,7 spare
// - status bit 0 low when healthy, high on any alarm or diagnostics
// - status bit 2 low while a calibration sequence runs
// - status bit 3 low while in diagnostic mode
// - status bit 4 low on any temperature alarm
// - status bit 5 low on any pressure alarm
// - status port B written at 324, all spare bits
// - relay word goes over i2c as sixteen bits to address 44 hex
// - relay bit 0 toggles at least every five seconds as keep-alive
// - heater bits 2,13,14,15 low turn heaters on
// - valve bits 5,7,9,10,11,12 low open valves
// - relay bit 6 low selects photometer reference position
// - relay bit 8 low runs the photometer pump
module idio_ports #(
	parameter [31:0] KEEPALIVE_CYC = `IDIO_KEEPALIVE_CYC,
	parameter [31:0] REFRESH_CYC = `IDIO_REFRESH_CYC,
	parameter [15:0] I2C_QTR_CYC = `IDIO_I2C_QTR
) (
	input wire core_clk_in, // 25 mhz clock
	input wire reset_n_in, // asynchronous reset, active low
	input wire [9:0] io_addr_in, // host i/o address
	input wire io_rd_in, // host read strobe
	input wire io_wr_in, // host write strobe, one cycle
	input wire [7:0] io_wdata_in, // host write data
	output reg [7:0] io_rdata_out, // host read data
	input wire relay_wr_in, // one-cycle write of relay word
	input wire [15:0] relay_word_in, // relay word from host
	output wire relay_busy_out, // i2c transfer in progress
	output wire relay_nack_out, // last transfer not acknowledged
	input wire [5:0] ctl_in_low_n_in, // control inputs one to six
	input wire [5:0] ctl_in_high_n_in, // control inputs seven to twelve
	input wire [7:0] internal_in_in, // spare internal inputs
	output reg [7:0] ctl_out_low_n_out, // control outputs one to eight
	output reg [3:0] ctl_out_high_n_out, // control outputs nine to twelve
	output reg [7:0] internal_out_out, // spare internal outputs
	output reg [7:0] status_a_out, // status lines, active low flags
	output reg [7:0] status_b_out, // spare status lines
	output wire healthy_flag_out, // status bit 0 level
	output wire sequence_running_flag_out, // status bit 2 level
	output wire diagnostic_flag_out, // status bit 3 level
	output wire thermal_alarm_flag_out, // status bit 4 level
	output wire pressure_alarm_flag_out, // status bit 5 level
	input wire i2c_scl_in, // i2c clock pin level
	input wire i2c_sda_in, // i2c data pin level
	output wire i2c_scl_o_out, // i2c clock output value, always 0
	output wire i2c_scl_oe_out, // i2c clock drive enable
	output wire i2c_sda_o_out, // i2c data output value, always 0
	output wire i2c_sda_oe_out // i2c data drive enable
);
	reg rst_s1_r, rst_n_r;
	reg [5:0] cil_s1_r, cil_r, cih_s1_r, cih_r;
	reg [7:0] int_s1_r, int_r;
	reg sda_s1_r, sda_r, scl_s1_r, scl_r;
	reg [15:0] relay_r;
	reg keep_r;
	reg [31:0] keep_cnt_r, refresh_cnt_r;
	reg pending_r;
	wire send;
	wire i2c_busy;

	function hit;
		input [9:0] addr;
		input [9:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// pins come from another domain, two stages before any use
	always @(posedge core_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cil_s1_r <= 6'h3f;
			cil_r <= 6'h3f;
			cih_s1_r <= 6'h3f;
			cih_r <= 6'h3f;
			int_s1_r <= 8'hff;
			int_r <= 8'hff;
			sda_s1_r <= 1'b1;
			sda_r <= 1'b1;
			scl_s1_r <= 1'b1;
			scl_r <= 1'b1;
		end else begin
			cil_s1_r <= ctl_in_low_n_in;
			cil_r <= cil_s1_r;
			cih_s1_r <= ctl_in_high_n_in;
			cih_r <= cih_s1_r;
			int_s1_r <= internal_in_in;
			int_r <= int_s1_r;
			sda_s1_r <= i2c_sda_in;
			sda_r <= sda_s1_r;
			scl_s1_r <= i2c_scl_in;
			scl_r <= scl_s1_r;
		end
	end

	always @* begin
		io_rdata_out = 8'hff;
		if (io_rd_in) begin
			if (hit(io_addr_in, `IDIO_ADDR_CTL_LOW))
				io_rdata_out = {`IDIO_SPARE_FILL, cil_r};
			else if (hit(io_addr_in, `IDIO_ADDR_CTL_HIGH))
				io_rdata_out = {`IDIO_SPARE_FILL, cih_r};
			else if (hit(io_addr_in, `IDIO_ADDR_INTERNAL))
				io_rdata_out = int_r;
		end
	end

	// outputs reset to all ones so nothing is asserted before software acts
	always @(posedge core_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctl_out_low_n_out <= `IDIO_PORT_RESET;
			ctl_out_high_n_out <= 4'hf;
			internal_out_out <= `IDIO_PORT_RESET;
			status_a_out <= `IDIO_PORT_RESET;
			status_b_out <= `IDIO_PORT_RESET;
		end else if (io_wr_in) begin
			if (hit(io_addr_in, `IDIO_ADDR_CTL_LOW))
				ctl_out_low_n_out <= io_wdata_in;
			if (hit(io_addr_in, `IDIO_ADDR_CTL_HIGH))
				ctl_out_high_n_out <= io_wdata_in[3:0];
			if (hit(io_addr_in, `IDIO_ADDR_INTERNAL))
				internal_out_out <= io_wdata_in;
			if (hit(io_addr_in, `IDIO_ADDR_STATUS_A))
				status_a_out <= io_wdata_in;
			if (hit(io_addr_in, `IDIO_ADDR_STATUS_B))
				status_b_out <= io_wdata_in;
		end
	end

	// flags are software's meaning; the port only carries them
	assign healthy_flag_out = status_a_out[`IDIO_ST_HEALTHY];
	assign sequence_running_flag_out = status_a_out[`IDIO_ST_SEQUENCE];
	assign diagnostic_flag_out = status_a_out[`IDIO_ST_DIAG];
	assign thermal_alarm_flag_out = status_a_out[`IDIO_ST_THERMAL];
	assign pressure_alarm_flag_out = status_a_out[`IDIO_ST_PRESSURE];

	// keep-alive bit is owned here, host bit 0 is ignored; the word is
	// resent on a refresh tick too so a lost frame is recovered
	always @(posedge core_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			relay_r <= `IDIO_RELAY_RESET;
			keep_r <= 1'b0;
			keep_cnt_r <= 32'h00000000;
			refresh_cnt_r <= 32'h00000000;
			pending_r <= 1'b1;
		end else begin
			if (relay_wr_in) begin
				relay_r[15:1] <= relay_word_in[15:1];
				pending_r <= 1'b1;
			end
			refresh_cnt_r <= refresh_cnt_r + 32'h00000001;
			if (refresh_cnt_r >= REFRESH_CYC - 32'h00000001) begin
				refresh_cnt_r <= 32'h00000000;
				pending_r <= 1'b1;
			end
			if (keep_cnt_r < KEEPALIVE_CYC)
				keep_cnt_r <= keep_cnt_r + 32'h00000001;
			// backstop if the refresh period is set too long; half the
			// window leaves room for a frame held off by a busy bus
			if (keep_cnt_r >= (KEEPALIVE_CYC >> 1))
				pending_r <= 1'b1;
			if (send) begin
				keep_r <= ~keep_r;
				keep_cnt_r <= 32'h00000000;
				if (!relay_wr_in)
					pending_r <= 1'b0;
			end
		end
	end

	// start only on a free bus; the synced levels also cover the last stop
	assign send = pending_r && !i2c_busy && scl_r && sda_r;

	idio_i2c_writer #(
		.QTR_CYC(I2C_QTR_CYC)
	) u_i2c (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_r),
		.start_in(send),
		.word_in({relay_r[15:1], ~keep_r}),
		.sda_in(sda_r),
		.busy_out(i2c_busy),
		.nack_out(relay_nack_out),
		.scl_oe_out(i2c_scl_oe_out),
		.sda_oe_out(i2c_sda_oe_out)
	);

	assign relay_busy_out = i2c_busy;
	assign i2c_scl_o_out = 1'b0;
	assign i2c_sda_o_out = 1'b0;
endmodule
`default_nettype wire

// ---- tb/idio_ports_checker.sv ----
// checker: port write effects, read fill bits and status flag wiring
`timescale 1ns/1ps
`default_nettype none
module idio_ports_checker (
	input wire logic core_clk_in, // clock
	input wire logic reset_n_in, // reset, active low
	input wire logic [9:0] io_addr_in, // host address
	input wire logic io_rd_in, // read qualifier
	input wire logic io_wr_in, // write strobe
	input wire logic [7:0] io_wdata_in, // write data
	input wire logic [7:0] io_rdata_out, // read data
	input wire logic [7:0] ctl_out_low_n_out, // outputs one to eight
	input wire logic [3:0] ctl_out_high_n_out, // outputs nine to twelve
	input wire logic [7:0] internal_out_out, // spare outputs
	input wire logic [7:0] status_a_out, // status port a
	input wire logic [7:0] status_b_out, // status port b
	input wire logic healthy_flag_out, // status bit 0
	input wire logic sequence_running_flag_out, // status bit 2
	input wire logic diagnostic_flag_out, // status bit 3
	input wire logic thermal_alarm_flag_out, // status bit 4
	input wire logic pressure_alarm_flag_out // status bit 5
);
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	AST_LOW: assert property (io_wr_in && io_addr_in == 10'h321
		|=> ctl_out_low_n_out == $past(io_wdata_in)) else $error("low write");
	AST_HOLD: assert property (!io_wr_in |=> $stable(ctl_out_low_n_out))
		else $error("low port moved without write");
	AST_HIGH: assert property (io_wr_in && io_addr_in == 10'h325
		|=> ctl_out_high_n_out == $past(io_wdata_in[3:0]))
		else $error("high write");
	AST_INT: assert property (io_wr_in && io_addr_in == 10'h322
		|=> internal_out_out == $past(io_wdata_in)) else $error("int write");
	AST_STA: assert property (io_wr_in && io_addr_in == 10'h323
		|=> status_a_out == $past(io_wdata_in)) else $error("status a");
	AST_STB: assert property (io_wr_in && io_addr_in == 10'h324
		|=> status_b_out == $past(io_wdata_in)) else $error("status b");
	AST_RD_LOW: assert property (io_rd_in && io_addr_in == 10'h321
		|-> io_rdata_out[7:6] == 2'h3) else $error("low read fill");
	AST_RD_HIGH: assert property (io_rd_in && io_addr_in == 10'h325
		|-> io_rdata_out[7:6] == 2'h3) else $error("high read fill");
	AST_FLAGS: assert property ({pressure_alarm_flag_out,
		thermal_alarm_flag_out, diagnostic_flag_out, sequence_running_flag_out,
		healthy_flag_out} == {status_a_out[5:2], status_a_out[0]})
		else $error("flag wiring");
endmodule
bind idio_ports idio_ports_checker idio_ports_checker_inst (
	.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
	.io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
	.io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
	.ctl_out_low_n_out(ctl_out_low_n_out),
	.ctl_out_high_n_out(ctl_out_high_n_out),
	.internal_out_out(internal_out_out), .status_a_out(status_a_out),
	.status_b_out(status_b_out), .healthy_flag_out(healthy_flag_out),
	.sequence_running_flag_out(sequence_running_flag_out),
	.diagnostic_flag_out(diagnostic_flag_out),
	.thermal_alarm_flag_out(thermal_alarm_flag_out),
	.pressure_alarm_flag_out(pressure_alarm_flag_out));
`default_nettype wire

// ---- tb/idio_ports_tb.sv ----
// testbench: host port writes and reads, relay word transfers
`timescale 1ns/1ps
`default_nettype none
module idio_ports_tb;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, rwr = 0;
	logic [9:0] addr = 10'h0;
	logic [7:0] wdata = 8'h0, int_in = 8'h5a, e;
	logic [5:0] in_lo = 6'h2a, in_hi = 6'h15;
	logic [15:0] rword = 16'hffff;
	wire busy, nack, scl_oe, sda_oe, m_oe, so, do_;
	wire [7:0] rdata, lo, io8, sa, sb;
	wire [3:0] hi;
	wire [4:0] fl;
	wire [15:0] mword, mprev;
	int frames, errors = 0, checks_done = 0, n, k;
	wire scl = ~scl_oe; // open drain lines with pull-ups
	wire sda = ~(sda_oe | m_oe);
	always #20 clk = ~clk;
	idio_ports #(.REFRESH_CYC(32'h7d0), .I2C_QTR_CYC(16'h2)) idio_ports_inst (
		.core_clk_in(clk), .reset_n_in(rst_n), .io_addr_in(addr),
		.io_rd_in(rd), .io_wr_in(wr), .io_wdata_in(wdata),
		.io_rdata_out(rdata), .relay_wr_in(rwr), .relay_word_in(rword),
		.relay_busy_out(busy), .relay_nack_out(nack),
		.ctl_in_low_n_in(in_lo), .ctl_in_high_n_in(in_hi),
		.internal_in_in(int_in), .ctl_out_low_n_out(lo),
		.ctl_out_high_n_out(hi), .internal_out_out(io8),
		.status_a_out(sa), .status_b_out(sb), .healthy_flag_out(fl[0]),
		.sequence_running_flag_out(fl[1]), .diagnostic_flag_out(fl[2]),
		.thermal_alarm_flag_out(fl[3]), .pressure_alarm_flag_out(fl[4]),
		.i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_scl_o_out(so),
		.i2c_scl_oe_out(scl_oe), .i2c_sda_o_out(do_),
		.i2c_sda_oe_out(sda_oe));
	idio_relay_model idio_relay_model_inst (.scl_in(scl), .sda_in(sda),
		.sda_oe_out(m_oe), .word_out(mword), .prev_out(mprev),
		.frames_out(frames));
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrp(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task rdc(input logic [9:0] a, input logic [7:0] x);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		chk("read", rdata, x);
		rd = 0;
	endtask
	task waitf(input int t);
		for (k = 0; k < 4000 && !(frames >= t && !busy); k++)
			@(negedge clk);
		if (k == 4000) begin
			errors++;
			$display("MISMATCH frame wait expected done seen timeout");
			complete_run;
		end
	endtask
	task rly(input logic [15:0] w);
		waitf(frames);
		n = frames;
		rword = w;
		rwr = 1;
		@(negedge clk);
		rwr = 0;
		// a frame launched at the write edge still carries the old word
		if (busy) n++;
		waitf(n + 1);
		chk("relay word", mword[15:1], w[15:1]);
		chk("keep alive", mword[0] ^ mprev[0], 1);
		chk("nack", nack, 0);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		waitf(1);
		chk("boot word", mword, 16'hffff);
		chk("open drain levels", {so, do_}, 2'h0);
		wrp(10'h321, 8'ha5);
		chk("low out", lo, 8'ha5);
		wrp(10'h325, 8'hf6);
		chk("high out", hi, 4'h6);
		wrp(10'h322, 8'h3c);
		chk("int out", io8, 8'h3c);
		wrp(10'h324, 8'h81);
		chk("status b", sb, 8'h81);
		wrp(10'h326, 8'h00);
		chk("unmapped", {lo, hi}, {8'ha5, 4'h6});
		for (n = 0; n < 8; n++) begin
			e = ~(8'h01 << n);
			wrp(10'h323, e);
			chk("status a", sa, e);
			chk("flags", fl, {e[5:2], e[0]});
		end
		$display("port write test done");
		rdc(10'h321, 8'hea);
		rdc(10'h325, 8'hd5);
		rdc(10'h322, 8'h5a);
		rdc(10'h326, 8'hff);
		rdc(10'h323, 8'hff);
		in_lo = 6'h15;
		in_hi = 6'h2a;
		repeat (2) @(negedge clk);
		rdc(10'h321, 8'hd5);
		rdc(10'h325, 8'hea);
		$display("port read test done");
		rly(16'h0f0a);
		rly(16'hf0f5);
		n = frames;
		waitf(n + 1);
		chk("refresh toggle", mword[0] ^ mprev[0], 1);
		chk("refresh word", mword[15:1], 15'h787a);
		$display("relay test done");
		complete_run;
	end
endmodule
`default_nettype wire

// ---- tb/idio_relay_model.sv ----
// relay board model: i2c slave that captures a sixteen-bit word
`timescale 1ns/1ps
`default_nettype none
module idio_relay_model (
	input wire logic scl_in, // bus clock level
	input wire logic sda_in, // bus data level
	output logic sda_oe_out, // high pulls data low to acknowledge
	output logic [15:0] word_out, // last complete word
	output logic [15:0] prev_out, // word of the frame before
	output int frames_out // complete frames seen
);
	logic [7:0] sh;
	logic [15:0] acc;
	int bits;
	int byten;
	initial begin
		sda_oe_out = 0;
		frames_out = 0;
		bits = 0;
		byten = 0;
		word_out = 16'hffff;
		prev_out = 16'hffff;
	end
	always @(negedge sda_in) if (scl_in) begin
		bits = 0;
		byten = 0;
	end
	// a frame counts only after address and both data bytes
	always @(posedge sda_in) if (scl_in && byten == 3) begin
		prev_out = word_out;
		word_out = acc;
		frames_out++;
		byten = 0;
	end
	always @(posedge scl_in) begin
		if (bits < 8)
			sh = {sh[6:0], sda_in};
		bits++;
	end
	always @(negedge scl_in) begin
		if (bits == 8) begin
			sda_oe_out = (byten != 0) || (sh == 8'h88);
			if (byten == 1)
				acc[7:0] = sh;
			if (byten == 2)
				acc[15:8] = sh;
		end else if (bits == 9) begin
			sda_oe_out = 0;
			bits = 0;
			byten++;
		end
	end
endmodule
`default_nettype wire
